// >>> verilog/spom_map.vh
// Register map, field layout, reset values and codes of the status output pin mux.
//
// Behaviour
// - Code 14 turns pins three and four into a CMOS-buffered receive input.
// - Code 15 turns pins three and four into a comparator receive input.
// - Fill substitution acts only when a masked error flag is set by an error.
// - Fill bit clear: output repeats the last valid sample while the flag stands.
// - Fill bit set: output data is all zeros while the masked flag stands.
// - Bypass bit clear (default): invalid flag drives automatic error handling.
// - Bypass bit set: the invalid flag causes no automatic error handling.
`ifndef SPOM_MAP_VH
`define SPOM_MAP_VH

// ----------------------------------------------------------------------------
// Register indexes; byte address is four times the index
// ----------------------------------------------------------------------------
`define SPOM_IDX_SEL_ONE_TWO    8'h26
`define SPOM_IDX_SEL_THREE_FOUR 8'h27
`define SPOM_IDX_IRQ_STATUS     8'h30
`define SPOM_IDX_IRQ_ENABLE     8'h31
`define SPOM_IDX_FLAG_STATE     8'h32

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SPOM_FLD_SEL_LO         3:0
`define SPOM_FLD_SEL_HI         7:4
`define SPOM_BIT_OPTION         8
`define SPOM_EVT_TRANSITION_ERROR_FLAG      0
`define SPOM_EVT_INVALID        1
`define SPOM_EVT_UNLOCK         2
`define SPOM_EVT_CS_UPDATE      3
`define SPOM_EVT_WIDTH          4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SPOM_RST_SEL_ONE        4'h0
`define SPOM_RST_SEL_TWO        4'h1
`define SPOM_RST_SEL_THREE      4'h2
`define SPOM_RST_SEL_FOUR       4'h3
`define SPOM_RST_FILL           1'b0
`define SPOM_RST_BYPASS         1'b0
`define SPOM_RST_IRQ_ENABLE     4'h0

// ----------------------------------------------------------------------------
// Selector codes
// ----------------------------------------------------------------------------
`define SPOM_SRC_COUNT          14
`define SPOM_SEL_RX_CMOS        4'hE
`define SPOM_SEL_RX_COMP        4'hF

`endif

// >>> verilog/spom_data_fill.v
// Receiver sample substitution while a masked error flag stands.
`timescale 1ns/1ps
`default_nettype none

module spom_data_fill (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        reset_n,
  // Incoming samples
  input  wire [23:0] sample_in,
  input  wire        sample_strobe,
  // Control
  input  wire        error_active,
  input  wire        fill_zero,
  // Outgoing samples
  output reg  [23:0] sample_out_reg,
  output reg         sample_out_strobe_reg
);

  reg [23:0] last_good_reg;

  // --------------------------------------------------------------------------
  // Substitution
  // --------------------------------------------------------------------------
  // A sample taken during an error is never stored as good, so with fill_zero
  // clear a long error burst keeps repeating the last clean sample.
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      sample_out_reg        <= 24'h000000;
      sample_out_strobe_reg <= 1'b0;
      last_good_reg         <= 24'h000000;
    end else begin
      sample_out_strobe_reg <= sample_strobe;
      if (sample_strobe) begin
        if (error_active) begin
          if (fill_zero) begin
            sample_out_reg <= 24'h000000;
          end else begin
            sample_out_reg <= last_good_reg;
          end
        end else begin
          sample_out_reg <= sample_in;
          last_good_reg  <= sample_in;
        end
      end
    end
  end

endmodule // spom_data_fill

`default_nettype wire

// >>> verilog/spom_top.v
// Status output pin mux with APB registers, interrupt and receiver error fill.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "spom_map.vh"

module spom_top (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        reset_n,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [9:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Receiver flags, same clock domain
  input  wire        validity_flag,
  input  wire        user_flag,
  input  wire        channel_status_flag,
  input  wire        parity_flag,
  input  wire        subframe_clock,
  input  wire        block_start_flag,
  input  wire        unlock_flag,
  input  wire        channel_status_updated,
  input  wire        invalid_flag,
  input  wire        zero_detect_flag,
  input  wire        compressed_payload_flag,
  input  wire        copy_permit_low,
  input  wire        emphasis_flag,
  input  wire        transition_error_flag,
  // Receiver samples
  input  wire [23:0] rx_sample_in,
  input  wire        rx_sample_strobe,
  output wire [23:0] rx_sample_out,
  output wire        rx_sample_out_strobe,
  // Output-only pins
  output wire        general_output_pin_one,
  output wire        general_output_pin_two,
  // Two-way pins
  input  wire        general_output_pin_three_in,
  output wire        general_output_pin_three_out,
  output wire        general_output_pin_three_oe,
  output wire        general_output_pin_three_comparator_en,
  input  wire        general_output_pin_four_in,
  output wire        general_output_pin_four_out,
  output wire        general_output_pin_four_oe,
  output wire        general_output_pin_four_comparator_en,
  // Receive input taken from a pin
  output wire        spdif_pin_rx,
  output wire        spdif_pin_rx_active,
  // Interrupt
  output wire        irq
);

  // --------------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------------
  // Codes at or above the source count select no flag, so the pin rests low.
  // Pins that cannot receive rely on this for codes 14 and 15.
  function spom_pick;
    input [3:0]  code;
    input [13:0] src;
    begin
      if (code < `SPOM_SRC_COUNT) begin
        spom_pick = src[code];
      end else begin
        spom_pick = 1'b0;
      end
    end
  endfunction

  // True for both receive codes, whichever input front end they pick.
  function spom_is_input;
    input [3:0] code;
    begin
      spom_is_input = (code == `SPOM_SEL_RX_CMOS) || (code == `SPOM_SEL_RX_COMP);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg  [3:0]  sel_one_reg;
  reg  [3:0]  sel_two_reg;
  reg  [3:0]  sel_three_reg;
  reg  [3:0]  sel_four_reg;
  reg         fill_zero_reg;
  reg         bypass_reg;
  reg  [3:0]  irq_status_reg;
  reg  [3:0]  irq_enable_reg;
  reg  [3:0]  evt_prev_reg;
  reg  [3:0]  pin_out_reg;
  wire [3:0]  pin_out_next;
  reg         pin_three_s1_reg;
  reg         pin_three_s2_reg;
  reg         pin_four_s1_reg;
  reg         pin_four_s2_reg;
  reg  [31:0] rdata_next;
  reg         hit_next;
  reg         addr_hit_reg;

  wire [7:0]  reg_index  = paddr[9:2];
  wire        setup_ph   = psel && !penable;
  wire        access_ph  = psel && penable;
  wire        wr_fire    = access_ph && pwrite;
  wire [3:0]  evt_level;
  wire [3:0]  evt_rise;
  wire [13:0] flag_vec;
  wire [15:0] sel_all;
  wire        error_active;

  // Every register answers from flops captured in the setup cycle, so the
  // slave never needs to stretch an access phase.
  assign pready  = 1'b1;
  assign pslverr = access_ph && !addr_hit_reg;

  // --------------------------------------------------------------------------
  // APB read decode
  // --------------------------------------------------------------------------
  always @* begin
    rdata_next = 32'h00000000;
    hit_next   = 1'b1;
    if (paddr[1:0] != 2'b00) begin
      hit_next = 1'b0;
    end else begin
      case (reg_index)
        `SPOM_IDX_SEL_ONE_TWO: begin
          rdata_next[`SPOM_FLD_SEL_LO] = sel_one_reg;
          rdata_next[`SPOM_FLD_SEL_HI] = sel_two_reg;
          rdata_next[`SPOM_BIT_OPTION] = fill_zero_reg;
        end
        `SPOM_IDX_SEL_THREE_FOUR: begin
          rdata_next[`SPOM_FLD_SEL_LO] = sel_three_reg;
          rdata_next[`SPOM_FLD_SEL_HI] = sel_four_reg;
          rdata_next[`SPOM_BIT_OPTION] = bypass_reg;
        end
        `SPOM_IDX_IRQ_STATUS: begin
          rdata_next[3:0] = irq_status_reg;
        end
        `SPOM_IDX_IRQ_ENABLE: begin
          rdata_next[3:0] = irq_enable_reg;
        end
        `SPOM_IDX_FLAG_STATE: begin
          rdata_next[13:0] = flag_vec;
        end
        default: begin
          hit_next = 1'b0;
        end
      endcase
    end
  end

  // Read data is captured in the setup cycle so the access phase answers
  // from flops without adding a wait state.
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      prdata       <= 32'h00000000;
      addr_hit_reg <= 1'b0;
    end else if (setup_ph) begin
      prdata       <= pwrite ? 32'h00000000 : rdata_next;
      addr_hit_reg <= hit_next;
    end
  end

  // --------------------------------------------------------------------------
  // APB writes and interrupt status
  // --------------------------------------------------------------------------
  assign evt_level[`SPOM_EVT_TRANSITION_ERROR_FLAG] = transition_error_flag;
  assign evt_level[`SPOM_EVT_INVALID]   = invalid_flag;
  assign evt_level[`SPOM_EVT_UNLOCK]    = unlock_flag;
  assign evt_level[`SPOM_EVT_CS_UPDATE] = channel_status_updated;
  // Events are taken on the rising edge of a flag level, so a flag that stays
  // high raises its status bit once and a clear is not undone by the level.
  assign evt_rise = evt_level & ~evt_prev_reg;

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      sel_one_reg    <= `SPOM_RST_SEL_ONE;
      sel_two_reg    <= `SPOM_RST_SEL_TWO;
      sel_three_reg  <= `SPOM_RST_SEL_THREE;
      sel_four_reg   <= `SPOM_RST_SEL_FOUR;
      fill_zero_reg  <= `SPOM_RST_FILL;
      bypass_reg     <= `SPOM_RST_BYPASS;
      irq_enable_reg <= `SPOM_RST_IRQ_ENABLE;
      irq_status_reg <= 4'h0;
      evt_prev_reg   <= 4'h0;
    end else begin
      evt_prev_reg <= evt_level;
      if (wr_fire && addr_hit_reg) begin
        case (reg_index)
          `SPOM_IDX_SEL_ONE_TWO: begin
            sel_one_reg   <= pwdata[`SPOM_FLD_SEL_LO];
            sel_two_reg   <= pwdata[`SPOM_FLD_SEL_HI];
            fill_zero_reg <= pwdata[`SPOM_BIT_OPTION];
          end
          `SPOM_IDX_SEL_THREE_FOUR: begin
            sel_three_reg <= pwdata[`SPOM_FLD_SEL_LO];
            sel_four_reg  <= pwdata[`SPOM_FLD_SEL_HI];
            bypass_reg    <= pwdata[`SPOM_BIT_OPTION];
          end
          `SPOM_IDX_IRQ_ENABLE: begin
            irq_enable_reg <= pwdata[3:0];
          end
          default: begin
          end
        endcase
      end
      // A new event in the clearing cycle keeps its bit set.
      if (wr_fire && addr_hit_reg && reg_index == `SPOM_IDX_IRQ_STATUS) begin
        irq_status_reg <= (irq_status_reg & ~pwdata[3:0]) | evt_rise;
      end else begin
        irq_status_reg <= irq_status_reg | evt_rise;
      end
    end
  end

  assign irq = |(irq_status_reg & irq_enable_reg);

  // --------------------------------------------------------------------------
  // Error fill
  // --------------------------------------------------------------------------
  // A flag counts as masked when its interrupt enable bit is clear.
  assign error_active =
    (transition_error_flag && !irq_enable_reg[`SPOM_EVT_TRANSITION_ERROR_FLAG]) ||
    (invalid_flag && !irq_enable_reg[`SPOM_EVT_INVALID] && !bypass_reg);

  spom_data_fill u_fill (
    .sys_clk               (sys_clk),
    .reset_n               (reset_n),
    .sample_in             (rx_sample_in),
    .sample_strobe         (rx_sample_strobe),
    .error_active          (error_active),
    .fill_zero             (fill_zero_reg),
    .sample_out_reg        (rx_sample_out),
    .sample_out_strobe_reg (rx_sample_out_strobe)
  );

  // --------------------------------------------------------------------------
  // Pin output mux
  // --------------------------------------------------------------------------
  assign flag_vec = {emphasis_flag, copy_permit_low, compressed_payload_flag,
                     zero_detect_flag, invalid_flag, channel_status_updated,
                     unlock_flag, block_start_flag, subframe_clock, parity_flag,
                     channel_status_flag, user_flag, validity_flag, ~irq};
  assign sel_all  = {sel_four_reg, sel_three_reg, sel_two_reg, sel_one_reg};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
      assign pin_out_next[gi] = spom_pick(sel_all[gi*4 +: 4], flag_vec);
    end
  endgenerate

  // Registering the pins keeps glitches of the selector decode off the board.
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      pin_out_reg <= 4'h0;
    end else begin
      pin_out_reg <= pin_out_next;
    end
  end

  // Pins one and two cannot receive; codes 14 and 15 simply drive them low.
  assign general_output_pin_one   = pin_out_reg[0];
  assign general_output_pin_two   = pin_out_reg[1];
  assign general_output_pin_three_out = pin_out_reg[2];
  assign general_output_pin_four_out  = pin_out_reg[3];
  assign general_output_pin_three_oe  = !spom_is_input(sel_three_reg);
  assign general_output_pin_four_oe   = !spom_is_input(sel_four_reg);
  assign general_output_pin_three_comparator_en =
    (sel_three_reg == `SPOM_SEL_RX_COMP);
  assign general_output_pin_four_comparator_en  =
    (sel_four_reg == `SPOM_SEL_RX_COMP);

  // --------------------------------------------------------------------------
  // Receive input from a pin
  // --------------------------------------------------------------------------
  // The board drives these pins with no relation to our clock; only the
  // second stage of each pair is read, to keep metastability off the logic.
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      pin_three_s1_reg <= 1'b0;
      pin_three_s2_reg <= 1'b0;
      pin_four_s1_reg  <= 1'b0;
      pin_four_s2_reg  <= 1'b0;
    end else begin
      pin_three_s1_reg <= general_output_pin_three_in;
      pin_three_s2_reg <= pin_three_s1_reg;
      pin_four_s1_reg  <= general_output_pin_four_in;
      pin_four_s2_reg  <= pin_four_s1_reg;
    end
  end

  // Pin three wins when both pins are set as receive inputs.
  // Software should pick one; the other pin then simply stays undriven.
  assign spdif_pin_rx_active = spom_is_input(sel_three_reg) || spom_is_input(sel_four_reg);
  assign spdif_pin_rx = spom_is_input(sel_three_reg) ? pin_three_s2_reg :
                        spom_is_input(sel_four_reg)  ? pin_four_s2_reg : 1'b0;

endmodule // spom_top

`default_nettype wire

// >>> bench/spom_far_side.sv
// Board pins and receiver flag logic facing the status output pin mux.
`timescale 1ns/1ps
`default_nettype none

module spom_far_side (
  // Clock
  input  wire logic        sys_clk,
  // Requested levels from the bench
  input  wire logic [13:0] flag_req,
  input  wire logic        board_three,
  input  wire logic        board_four,
  // Pin drive from the design
  input  wire logic        three_out,
  input  wire logic        three_oe,
  input  wire logic        four_out,
  input  wire logic        four_oe,
  // Towards the design
  output var  logic [13:0] flag_reg,
  output wire logic        three_in,
  output wire logic        four_in
);
  initial flag_reg = 14'h0;
  // Receiver flags come out of registers, so they only move after an edge.
  always @(posedge sys_clk) begin
    flag_reg <= flag_req;
  end
  // The board source only reaches the wire once the design lets go of it.
  assign three_in = three_oe ? three_out : board_three;
  assign four_in  = four_oe ? four_out : board_four;
endmodule // spom_far_side

`default_nettype wire

// >>> bench/spom_monitor.sv
// Concurrent checks on the ports of the status output pin mux.
`timescale 1ns/1ps
`default_nettype none

module spom_monitor (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // Register bus, snooped to mirror the control fields
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [9:0]  paddr,
  input wire logic [31:0] pwdata,
  // Selector sources, invalid_flag listed before channel_status_updated, then transition_error_flag for the error fill
  input wire logic        irq, validity_flag, user_flag, channel_status_flag, parity_flag,
  input wire logic        subframe_clock, block_start_flag, unlock_flag, invalid_flag,
  input wire logic        channel_status_updated, zero_detect_flag, compressed_payload_flag,
  input wire logic        copy_permit_low, emphasis_flag, transition_error_flag,
  // Samples and pins
  input wire logic [23:0] rx_sample_in,
  input wire logic        rx_sample_strobe,
  input wire logic [23:0] rx_sample_out,
  input wire logic        general_output_pin_one,
  input wire logic        general_output_pin_three_in,
  input wire logic        general_output_pin_three_oe,
  input wire logic        general_output_pin_four_oe,
  input wire logic        general_output_pin_three_comparator_en,
  input wire logic        spdif_pin_rx,
  input wire logic        spdif_pin_rx_active
);
  logic [3:0]  s1_reg, s3_reg, s4_reg, en_reg;
  logic        fill_reg, byp_reg;
  logic [23:0] good_reg;
  wire  [13:0] src = {emphasis_flag, copy_permit_low, compressed_payload_flag,
                      zero_detect_flag, invalid_flag, channel_status_updated, unlock_flag,
                      block_start_flag, subframe_clock, parity_flag, channel_status_flag,
                      user_flag, validity_flag, ~irq};
  wire         exp1 = (s1_reg < 4'hE) ? src[s1_reg] : 1'b0;
  wire         wr   = psel & penable & pwrite;
  wire         err  = (transition_error_flag & ~en_reg[0])
                    | (invalid_flag & ~en_reg[1] & ~byp_reg);
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      {fill_reg, s1_reg} <= {1'b0, 4'h0};
      {byp_reg, s4_reg, s3_reg} <= {1'b0, 4'h3, 4'h2};
      en_reg <= 4'h0;
      good_reg <= 24'h0;
    end else begin
      if (wr && paddr == 10'h098) {fill_reg, s1_reg} <= {pwdata[8], pwdata[3:0]};
      if (wr && paddr == 10'h09C) {byp_reg, s4_reg, s3_reg} <= pwdata[8:0];
      if (wr && paddr == 10'h0C4) en_reg <= pwdata[3:0];
      if (rx_sample_strobe && !err) good_reg <= rx_sample_in;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_pin_one;
    $past(reset_n) |-> general_output_pin_one == $past(exp1);
  endproperty
  a_pin_one: assert property (p_pin_one) else $error("pin one source wrong");
  property p_oe;
    general_output_pin_three_oe == (s3_reg < 4'hE) && general_output_pin_four_oe == (s4_reg < 4'hE);
  endproperty
  a_oe: assert property (p_oe) else $error("pin drive enable wrong");
  property p_comp;
    general_output_pin_three_comparator_en == (s3_reg == 4'hF);
  endproperty
  a_comp: assert property (p_comp) else $error("comparator enable wrong");
  property p_rx_act;
    spdif_pin_rx_active == (s3_reg >= 4'hE || s4_reg >= 4'hE);
  endproperty
  a_rx_act: assert property (p_rx_act) else $error("receive input flag wrong");
  property p_rx_in;
    (s3_reg >= 4'hE) [*3] |-> spdif_pin_rx == $past(general_output_pin_three_in, 2);
  endproperty
  a_rx_in: assert property (p_rx_in) else $error("receive input level wrong");
  property p_fill_zero;
    rx_sample_strobe && err && fill_reg |=> rx_sample_out == 24'h0;
  endproperty
  a_fill_zero: assert property (p_fill_zero) else $error("sample not zeroed");
  property p_fill_hold;
    rx_sample_strobe && err && !fill_reg |=> rx_sample_out == $past(good_reg);
  endproperty
  a_fill_hold: assert property (p_fill_hold) else $error("last sample not held");
  property p_pass;
    rx_sample_strobe && !err |=> rx_sample_out == $past(rx_sample_in);
  endproperty
  a_pass: assert property (p_pass) else $error("sample not passed");
  c_fill_zero: cover property (rx_sample_strobe && err && fill_reg);
  c_fill_hold: cover property (rx_sample_strobe && err && !fill_reg);
  c_rx_in: cover property ((s3_reg >= 4'hE) [*3]);
endmodule // spom_monitor

bind spom_top spom_monitor u_mon (
  .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .irq(irq), .validity_flag(validity_flag),
  .user_flag(user_flag), .channel_status_flag(channel_status_flag),
  .parity_flag(parity_flag), .subframe_clock(subframe_clock),
  .block_start_flag(block_start_flag), .unlock_flag(unlock_flag),
  .invalid_flag(invalid_flag), .channel_status_updated(channel_status_updated),
  .zero_detect_flag(zero_detect_flag), .compressed_payload_flag(compressed_payload_flag),
  .copy_permit_low(copy_permit_low), .emphasis_flag(emphasis_flag),
  .transition_error_flag(transition_error_flag), .rx_sample_in(rx_sample_in),
  .rx_sample_strobe(rx_sample_strobe), .rx_sample_out(rx_sample_out),
  .general_output_pin_one(general_output_pin_one),
  .general_output_pin_three_in(general_output_pin_three_in),
  .general_output_pin_three_oe(general_output_pin_three_oe),
  .general_output_pin_four_oe(general_output_pin_four_oe),
  .general_output_pin_three_comparator_en(general_output_pin_three_comparator_en),
  .spdif_pin_rx(spdif_pin_rx), .spdif_pin_rx_active(spdif_pin_rx_active));

`default_nettype wire

// >>> bench/tb_status_output_pin_mux.sv
// Self-checking bench of the status output pin mux.
`timescale 1ns/1ps
`default_nettype none

module tb_status_output_pin_mux;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, smp_stb = 1'b0;
  logic        b3 = 1'b0, b4 = 1'b0, serr;
  logic [9:0]  paddr = 10'h000;
  logic [31:0] pwdata = 32'h0, q;
  logic [23:0] smp_in = 24'h0;
  logic [13:0] fset = 14'h0;
  wire  [13:0] fl;
  wire  [23:0] smp_out;
  wire  [31:0] prdata;
  wire         pready, pslverr, smp_ostb, p1, p2, p3o, p3e, p3c, p3i, p4o, p4e, p4c, p4i;
  wire         rx, rx_act, irq;
  int          n_mismatch = 0;
  int          n_compared = 0;

  always #12.5 sys_clk = ~sys_clk;

  spom_far_side u_far (
    .sys_clk(sys_clk), .flag_req(fset), .board_three(b3), .board_four(b4),
    .three_out(p3o), .three_oe(p3e), .four_out(p4o), .four_oe(p4e),
    .flag_reg(fl), .three_in(p3i), .four_in(p4i));

  spom_top u_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .transition_error_flag(fl[0]),
    .validity_flag(fl[1]), .user_flag(fl[2]), .channel_status_flag(fl[3]),
    .parity_flag(fl[4]), .subframe_clock(fl[5]), .block_start_flag(fl[6]),
    .unlock_flag(fl[7]), .channel_status_updated(fl[8]), .invalid_flag(fl[9]),
    .zero_detect_flag(fl[10]), .compressed_payload_flag(fl[11]),
    .copy_permit_low(fl[12]), .emphasis_flag(fl[13]),
    .rx_sample_in(smp_in), .rx_sample_strobe(smp_stb), .rx_sample_out(smp_out),
    .rx_sample_out_strobe(smp_ostb), .general_output_pin_one(p1),
    .general_output_pin_two(p2), .general_output_pin_three_in(p3i),
    .general_output_pin_three_out(p3o), .general_output_pin_three_oe(p3e),
    .general_output_pin_three_comparator_en(p3c), .general_output_pin_four_in(p4i),
    .general_output_pin_four_out(p4o), .general_output_pin_four_oe(p4e),
    .general_output_pin_four_comparator_en(p4c), .spdif_pin_rx(rx),
    .spdif_pin_rx_active(rx_act), .irq(irq));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) chk("pready", 32'h1, 32'h0);
    q = prdata;
    serr = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  task automatic rd(input string nm, input logic [9:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask

  // The wait covers the partner's register plus the design's pin stage.
  task automatic drv(input logic [13:0] f, input logic v3, input logic v4);
    @(posedge sys_clk);
    {fset, b3, b4} <= {f, v3, v4};
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic smp(input logic [23:0] d, input logic [23:0] e);
    @(posedge sys_clk);
    {smp_in, smp_stb} <= {d, 1'b1};
    @(posedge sys_clk);
    smp_stb <= 1'b0;
    @(negedge sys_clk);
    chk("sample", {7'h0, 1'b1, e}, {7'h0, smp_ostb, smp_out});
  endtask

  task automatic conclude();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd("select one two", 10'h098, 32'h10);
    rd("select three four", 10'h09C, 32'h32);
    xfer(1'b1, 10'h0FC, 32'hFFFFFFFF);
    chk("slave error", 32'h1, 32'(serr));
    rd("unmapped", 10'h0FC, 32'h0);
    xfer(1'b1, 10'h098, 32'hFFFFFFFF);
    rd("select one two", 10'h098, 32'h1FF);
    xfer(1'b1, 10'h099, 32'h0);
    chk("misaligned error", 32'h1, 32'(serr));
    rd("select one two", 10'h098, 32'h1FF);
    for (int c = 0; c < 14; c++) begin
      xfer(1'b1, 10'h098, {24'h0, c[3:0], c[3:0]});
      xfer(1'b1, 10'h09C, {24'h0, c[3:0], c[3:0]});
      for (int v = 0; v < 2; v++) begin
        drv(v[0] ? 14'h1 << c : 14'h0, 1'b0, 1'b0);
        chk("pins", 32'({4{c == 0 || v[0]}}), 32'({p1, p2, p3o, p4o}));
        chk("drive enables", 32'h3, 32'({p3e, p4e}));
      end
    end
    xfer(1'b1, 10'h098, 32'hFE);
    for (int m = 0; m < 2; m++) begin
      xfer(1'b1, 10'h09C, m ? 32'hE0 : 32'hFE);
      for (int v = 0; v < 2; v++) begin
        drv(14'h3FFE, v[0] ^ m[0], v[0]);
        chk("refused pins", 32'h0, 32'({p1, p2}));
        chk("pin modes", m ? 32'h8 : 32'h1, 32'({p3e, p4e, p3c, p4c}));
        chk("receive input", {30'h0, v[0], 1'b1}, 32'({rx, rx_act}));
      end
    end
    rd("flag state", 10'h0C8, 32'h3FFF);
    xfer(1'b1, 10'h09C, 32'h32);
    xfer(1'b1, 10'h0C0, 32'hF);
    rd("status", 10'h0C0, 32'h0);
    xfer(1'b1, 10'h0C4, 32'h1);
    rd("irq enable", 10'h0C4, 32'h1);
    drv(14'h1, 1'b0, 1'b0);
    chk("irq raised", 32'h1, 32'(irq));
    rd("status", 10'h0C0, 32'h1);
    xfer(1'b1, 10'h0C4, 32'h0);
    @(negedge sys_clk);
    chk("irq masked", 32'h0, 32'(irq));
    xfer(1'b1, 10'h0C4, 32'h1);
    xfer(1'b1, 10'h0C0, 32'h1);
    @(negedge sys_clk);
    chk("irq cleared", 32'h0, 32'(irq));
    xfer(1'b1, 10'h0C4, 32'h0);
    xfer(1'b1, 10'h098, 32'h10);
    drv(14'h0, 1'b0, 1'b0);
    smp(24'h123456, 24'h123456);
    drv(14'h1, 1'b0, 1'b0);
    smp(24'hABCDEF, 24'h123456);
    xfer(1'b1, 10'h098, 32'h110);
    smp(24'h654321, 24'h0);
    xfer(1'b1, 10'h0C4, 32'h1);
    smp(24'h777777, 24'h777777);
    xfer(1'b1, 10'h0C4, 32'h0);
    drv(14'h200, 1'b0, 1'b0);
    smp(24'h0F0F0F, 24'h0);
    xfer(1'b1, 10'h09C, 32'h132);
    smp(24'h5A5A5A, 24'h5A5A5A);
    xfer(1'b1, 10'h09C, 32'h32);
    xfer(1'b1, 10'h098, 32'h10);
    smp(24'hC3C3C3, 24'h5A5A5A);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    conclude();
  end
endmodule // tb_status_output_pin_mux

`default_nettype wire
